// >>> pkg/level_probe_defines.svh
// Constants for the level probe holding-register map and its request checks
`ifndef LEVEL_PROBE_DEFINES_SVH
`define LEVEL_PROBE_DEFINES_SVH

// ------------------------------------------------------------------
// Function and exception codes
// ------------------------------------------------------------------
`define FUNC_READ_HOLDING     8'h03
`define EXC_ILLEGAL_FUNCTION  8'h01
`define EXC_ILLEGAL_ADDRESS   8'h02
`define EXC_ILLEGAL_QUANTITY  8'h03
`define EXC_PROBE_FAILURE     8'h04
`define EXC_MEMORY_ERROR      8'h08
`define EXC_NONE              8'h00

// ------------------------------------------------------------------
// Address span and quantity limits
// ------------------------------------------------------------------
`define MAP_LAST_ADDR         17'h0_0023
`define QTY_MIN               16'h0001
`define QTY_MAX               16'h007D
`define QTY_ONE               16'h0001
`define PTR_STEP              16'h0001

// ------------------------------------------------------------------
// Register offsets (register index within the map)
// ------------------------------------------------------------------
`define OFS_USER_FLOAT_HI     6'h00
`define OFS_USER_FLOAT_LO     6'h01
`define OFS_PRESS1_FLOAT_HI   6'h02
`define OFS_PRESS1_FLOAT_LO   6'h03
`define OFS_PRESS2_FLOAT_HI   6'h04
`define OFS_PRESS2_FLOAT_LO   6'h05
`define OFS_TEMP1_FLOAT_HI    6'h06
`define OFS_TEMP1_FLOAT_LO    6'h07
`define OFS_CPU_FLOAT_HI      6'h08
`define OFS_CPU_FLOAT_LO      6'h09
`define OFS_TEMP2_FLOAT_HI    6'h0A
`define OFS_TEMP2_FLOAT_LO    6'h0B
`define OFS_SLOT_A_HI         6'h0C
`define OFS_SLOT_A_LO         6'h0D
`define OFS_SLOT_B_HI         6'h0E
`define OFS_SLOT_B_LO         6'h0F
`define OFS_USER_INT          6'h10
`define OFS_PRESS1_INT        6'h11
`define OFS_PRESS2_INT        6'h12
`define OFS_TEMP1_INT         6'h13
`define OFS_CPU_INT           6'h14
`define OFS_TEMP2_INT         6'h15
`define OFS_UNIT_CODE         6'h16
`define OFS_SLOT_C            6'h17
`define OFS_RANGE_UPPER_HI    6'h18
`define OFS_RANGE_UPPER_LO    6'h19
`define OFS_RANGE_LOWER_HI    6'h1A
`define OFS_RANGE_LOWER_LO    6'h1B
`define OFS_DAMPING_HI        6'h1C
`define OFS_DAMPING_LO        6'h1D
`define OFS_REPLY_DELAY       6'h1E
`define OFS_SLAVE_ADDRESS     6'h1F
`define OFS_IDENT_0           6'h20
`define OFS_IDENT_1           6'h21
`define OFS_IDENT_2           6'h22
`define OFS_LIMIT_STATUS      6'h23

// ------------------------------------------------------------------
// Field positions and fixed values
// ------------------------------------------------------------------
`define STATUS_PRI_BIT        5
`define STATUS_STV_BIT        6
`define WORD_ZERO             16'h0000
`define BYTE_ZERO             8'h00

`endif

// >>> pkg/level_probe_pkg.sv
// Types shared by the level probe register bank modules
package level_probe_pkg;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_CHECK = 2'b01,
      ST_FETCH = 2'b10,
      ST_SEND  = 2'b11
   } fsm_state_type;

   typedef struct packed {
      fsm_state_type fsm;
      logic [7:0]    func;
      logic [15:0]   pointer;
      logic [15:0]   remaining;
      logic [15:0]   count;
      logic          probe_fault;
      logic          memory_fault;
      logic [31:0]   user_float;
      logic [31:0]   pressure_float;
      logic [31:0]   temperature_float;
      logic [31:0]   cpu_float;
      logic [31:0]   range_upper;
      logic [31:0]   range_lower;
      logic [31:0]   damping;
      logic [15:0]   user_int;
      logic [15:0]   pressure_int;
      logic [15:0]   temperature_int;
      logic [15:0]   cpu_int;
      logic [15:0]   unit;
      logic [15:0]   reply_delay;
      logic [7:0]    slave;
      logic [47:0]   ident;
      logic          pri_limit;
      logic          stv_limit;
      logic          rsp_valid;
      logic          rsp_error;
      logic [7:0]    rsp_code;
      logic [7:0]    rsp_byte_count;
      logic [15:0]   rsp_word;
      logic          rsp_last;
   } state_type;

endpackage

// >>> logic/holding_register_mux.sv
// Read decode of the holding-register map from a frozen sample
`timescale 1ns/1ps
`include "level_probe_defines.svh"

module holding_register_mux
   import level_probe_pkg::*;
(
   input  wire logic [5:0]  address,
   input  wire logic [31:0] user_float,
   input  wire logic [31:0] pressure_float,
   input  wire logic [31:0] temperature_float,
   input  wire logic [31:0] cpu_float,
   input  wire logic [31:0] range_upper,
   input  wire logic [31:0] range_lower,
   input  wire logic [31:0] damping,
   input  wire logic [15:0] user_int,
   input  wire logic [15:0] pressure_int,
   input  wire logic [15:0] temperature_int,
   input  wire logic [15:0] cpu_int,
   input  wire logic [15:0] unit,
   input  wire logic [15:0] reply_delay,
   input  wire logic [7:0]  slave,
   input  wire logic [47:0] ident,
   input  wire logic        pri_limit,
   input  wire logic        stv_limit,
   output logic      [15:0] word
);

   logic [15:0] status_word;

   always_comb begin
      status_word                  = `WORD_ZERO;
      status_word[`STATUS_PRI_BIT] = pri_limit;
      status_word[`STATUS_STV_BIT] = stv_limit;
   end

   // Floats go out high half first, at the even offset
   always_comb begin
      unique case (address)
         `OFS_USER_FLOAT_HI:   word = user_float[31:16];
         `OFS_USER_FLOAT_LO:   word = user_float[15:0];
         `OFS_PRESS1_FLOAT_HI: word = pressure_float[31:16];
         `OFS_PRESS1_FLOAT_LO: word = pressure_float[15:0];
         `OFS_TEMP1_FLOAT_HI:  word = temperature_float[31:16];
         `OFS_TEMP1_FLOAT_LO:  word = temperature_float[15:0];
         `OFS_CPU_FLOAT_HI:    word = cpu_float[31:16];
         `OFS_CPU_FLOAT_LO:    word = cpu_float[15:0];
         `OFS_USER_INT:        word = user_int;
         `OFS_PRESS1_INT:      word = pressure_int;
         `OFS_TEMP1_INT:       word = temperature_int;
         `OFS_CPU_INT:         word = cpu_int;
         `OFS_UNIT_CODE:       word = unit;
         `OFS_RANGE_UPPER_HI:  word = range_upper[31:16];
         `OFS_RANGE_UPPER_LO:  word = range_upper[15:0];
         `OFS_RANGE_LOWER_HI:  word = range_lower[31:16];
         `OFS_RANGE_LOWER_LO:  word = range_lower[15:0];
         `OFS_DAMPING_HI:      word = damping[31:16];
         `OFS_DAMPING_LO:      word = damping[15:0];
         `OFS_REPLY_DELAY:     word = reply_delay;
         `OFS_SLAVE_ADDRESS:   word = {`BYTE_ZERO, slave};
         `OFS_IDENT_0:         word = ident[47:32];
         `OFS_IDENT_1:         word = ident[31:16];
         `OFS_IDENT_2:         word = ident[15:0];
         `OFS_LIMIT_STATUS:    word = status_word;
         // Second sensor and empty slots read as zero
         default:              word = `WORD_ZERO;
      endcase
   end

endmodule // holding_register_mux

// >>> logic/level_probe_register_bank.sv
// Read-only holding-register bank and request checker of the level probe
`timescale 1ns/1ps
`include "level_probe_defines.svh"

module level_probe_register_bank
   import level_probe_pkg::*;
(
   input  wire logic        CLK_SYS,
   input  wire logic        SYS_RST,
   input  wire logic        REQ_VALID,
   output logic             REQ_READY,
   input  wire logic [7:0]  REQ_FUNCTION,
   input  wire logic [15:0] REQ_START,
   input  wire logic [15:0] REQ_QUANTITY,
   output logic             RSP_VALID,
   input  wire logic        RSP_READY,
   output logic             RSP_ERROR,
   output logic      [7:0]  RSP_CODE,
   output logic      [7:0]  RSP_BYTE_COUNT,
   output logic      [15:0] RSP_WORD,
   output logic             RSP_LAST,
   input  wire logic [31:0] USER_PERCENT_FLOAT,
   input  wire logic [31:0] PRESSURE_FLOAT,
   input  wire logic [31:0] TEMPERATURE_FLOAT,
   input  wire logic [31:0] CPU_TEMPERATURE_FLOAT,
   input  wire logic [31:0] RANGE_UPPER_FLOAT,
   input  wire logic [31:0] RANGE_LOWER_FLOAT,
   input  wire logic [31:0] DAMPING_FLOAT,
   input  wire logic [31:0] USER_PERCENT_SCALED,
   input  wire logic [31:0] PRESSURE_SCALED,
   input  wire logic [31:0] TEMPERATURE_SCALED,
   input  wire logic [31:0] CPU_TEMPERATURE_SCALED,
   input  wire logic [15:0] UNIT_CODE,
   input  wire logic [15:0] REPLY_DELAY_MS,
   input  wire logic [7:0]  SLAVE_ADDRESS,
   input  wire logic [47:0] IDENTIFICATION,
   input  wire logic        PRIMARY_VARIABLE_OUT_OF_LIMIT,
   input  wire logic        SECONDARY_TERTIARY_FOURTH_VARIABLES_OUT_OF_LIMIT,
   input  wire logic        PROBE_FAULT,
   input  wire logic        MEMORY_FAULT
);

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------

   // Only the low half is kept, so an out-of-range value wraps
   function automatic logic [15:0] scaled_to_register(input logic [31:0] value);
      scaled_to_register = value[15:0];
   endfunction

   // Index of the last register a request touches, one bit wider than the start
   function automatic logic [16:0] last_register(input logic [15:0] start,
                                                 input logic [15:0] count);
      last_register = {1'b0, start} + {1'b0, count} - {1'b0, `QTY_ONE};
   endfunction

   // Checks run in the order a slave normally applies them
   function automatic logic [7:0] exception_code(input logic [7:0]  func,
                                                 input logic [15:0] start,
                                                 input logic [15:0] count,
                                                 input logic        probe_fault,
                                                 input logic        memory_fault);
      if (func != `FUNC_READ_HOLDING) begin
         exception_code = `EXC_ILLEGAL_FUNCTION;
      end else if (count < `QTY_MIN || count > `QTY_MAX) begin
         exception_code = `EXC_ILLEGAL_QUANTITY;
      end else if (last_register(start, count) > `MAP_LAST_ADDR) begin
         exception_code = `EXC_ILLEGAL_ADDRESS;
      end else if (probe_fault) begin
         exception_code = `EXC_PROBE_FAILURE;
      end else if (memory_fault) begin
         exception_code = `EXC_MEMORY_ERROR;
      end else begin
         exception_code = `EXC_NONE;
      end
   endfunction

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   state_type   state;
   state_type   next_state;
   logic [15:0] map_word;
   logic [7:0]  check_code;

   holding_register_mux u_map (
      .address           (state.pointer[5:0]),
      .user_float        (state.user_float),
      .pressure_float    (state.pressure_float),
      .temperature_float (state.temperature_float),
      .cpu_float         (state.cpu_float),
      .range_upper       (state.range_upper),
      .range_lower       (state.range_lower),
      .damping           (state.damping),
      .user_int          (state.user_int),
      .pressure_int      (state.pressure_int),
      .temperature_int   (state.temperature_int),
      .cpu_int           (state.cpu_int),
      .unit              (state.unit),
      .reply_delay       (state.reply_delay),
      .slave             (state.slave),
      .ident             (state.ident),
      .pri_limit         (state.pri_limit),
      .stv_limit         (state.stv_limit),
      .word              (map_word)
   );

   assign check_code = exception_code(state.func, state.pointer, state.count,
                                      state.probe_fault, state.memory_fault);

   // ------------------------------------------------------------------
   // Request sequencer
   // ------------------------------------------------------------------
   always_comb begin
      next_state = state;
      unique case (state.fsm)
         ST_IDLE: begin
            // One request at a time; the master waits for the answer
            if (REQ_VALID) begin
               next_state.func         = REQ_FUNCTION;
               next_state.pointer      = REQ_START;
               next_state.count        = REQ_QUANTITY;
               next_state.probe_fault  = PROBE_FAULT;
               next_state.memory_fault = MEMORY_FAULT;
               // Whole map frozen here so a reply never mixes two samples
               next_state.user_float        = USER_PERCENT_FLOAT;
               next_state.pressure_float    = PRESSURE_FLOAT;
               next_state.temperature_float = TEMPERATURE_FLOAT;
               next_state.cpu_float         = CPU_TEMPERATURE_FLOAT;
               next_state.range_upper       = RANGE_UPPER_FLOAT;
               next_state.range_lower       = RANGE_LOWER_FLOAT;
               next_state.damping           = DAMPING_FLOAT;
               next_state.user_int          = scaled_to_register(USER_PERCENT_SCALED);
               next_state.pressure_int      = scaled_to_register(PRESSURE_SCALED);
               next_state.temperature_int   = scaled_to_register(TEMPERATURE_SCALED);
               next_state.cpu_int           = scaled_to_register(CPU_TEMPERATURE_SCALED);
               next_state.unit              = UNIT_CODE;
               next_state.reply_delay       = REPLY_DELAY_MS;
               next_state.slave             = SLAVE_ADDRESS;
               next_state.ident             = IDENTIFICATION;
               next_state.pri_limit         = PRIMARY_VARIABLE_OUT_OF_LIMIT;
               next_state.stv_limit         =
                  SECONDARY_TERTIARY_FOURTH_VARIABLES_OUT_OF_LIMIT;
               next_state.fsm               = ST_CHECK;
            end
         end
         ST_CHECK: begin
            if (check_code != `EXC_NONE) begin
               // A refused request touches nothing; only the code goes back
               next_state.rsp_valid      = 1'b1;
               next_state.rsp_error      = 1'b1;
               next_state.rsp_code       = check_code;
               next_state.rsp_byte_count = `BYTE_ZERO;
               next_state.rsp_word       = `WORD_ZERO;
               next_state.rsp_last       = 1'b1;
               next_state.fsm            = ST_SEND;
            end else begin
               next_state.remaining = state.count;
               next_state.fsm       = ST_FETCH;
            end
         end
         ST_FETCH: begin
            next_state.rsp_valid      = 1'b1;
            next_state.rsp_error      = 1'b0;
            next_state.rsp_code       = state.func;
            next_state.rsp_byte_count = {state.count[6:0], 1'b0};
            next_state.rsp_word       = map_word;
            next_state.rsp_last       = (state.remaining == `QTY_ONE);
            next_state.fsm            = ST_SEND;
         end
         ST_SEND: begin
            if (RSP_READY) begin
               next_state.rsp_valid = 1'b0;
               if (state.rsp_last) begin
                  next_state.fsm = ST_IDLE;
               end else begin
                  next_state.pointer   = state.pointer + `PTR_STEP;
                  next_state.remaining = state.remaining - `QTY_ONE;
                  next_state.fsm       = ST_FETCH;
               end
            end
         end
      endcase
   end

   // No write path exists: bus requests only ever read the frozen sample
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign REQ_READY      = (state.fsm == ST_IDLE);
   assign RSP_VALID      = state.rsp_valid;
   assign RSP_ERROR      = state.rsp_error;
   assign RSP_CODE       = state.rsp_code;
   assign RSP_BYTE_COUNT = state.rsp_byte_count;
   assign RSP_WORD       = state.rsp_word;
   assign RSP_LAST       = state.rsp_last;

endmodule // level_probe_register_bank

// >>> verification/level_probe_register_bank_monitor.sv
// Assertion checker watching the level probe register bank ports
`timescale 1ns/1ps
module level_probe_register_bank_monitor (
   input logic        CLK_SYS,
   input logic        SYS_RST,
   input logic        REQ_VALID,
   input logic        REQ_READY,
   input logic [7:0]  REQ_FUNCTION,
   input logic [15:0] REQ_START,
   input logic [15:0] REQ_QUANTITY,
   input logic        RSP_VALID,
   input logic        RSP_READY,
   input logic        RSP_ERROR,
   input logic [7:0]  RSP_CODE,
   input logic [7:0]  RSP_BYTE_COUNT,
   input logic [15:0] RSP_WORD,
   input logic        RSP_LAST,
   input logic        PROBE_FAULT,
   input logic        MEMORY_FAULT
);
   // ---------------------------------------------------------------
   // Expected exception of the request on the port
   // ---------------------------------------------------------------
   logic        taken;
   logic [7:0]  want;
   logic [16:0] top;
   assign taken = REQ_VALID && REQ_READY;
   // 17 bits so a high start cannot wrap
   assign top = {1'b0, REQ_START} + {1'b0, REQ_QUANTITY} - 17'h0_0001;
   always_comb begin
      if (REQ_FUNCTION != 8'h03) want = 8'h01;
      else if (REQ_QUANTITY == 16'h0000 || REQ_QUANTITY > 16'h007D) want = 8'h03;
      else if (top > 17'h0_0023) want = 8'h02;
      else if (PROBE_FAULT) want = 8'h04;
      else if (MEMORY_FAULT) want = 8'h08;
      else want = 8'h00;
   end
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (SYS_RST);
   property p_exception;
      taken && want != 8'h00 |-> ##1 !RSP_VALID ##1 RSP_VALID && RSP_ERROR
         && RSP_CODE == $past(want, 2);
   endproperty
   a_exception: assert property (p_exception) else $error("exception reply wrong");
   property p_data;
      taken && want == 8'h00 |-> ##1 !RSP_VALID [*2] ##1 RSP_VALID && !RSP_ERROR
         && RSP_CODE == 8'h03 && RSP_BYTE_COUNT == 8'($past(REQ_QUANTITY, 3) << 1);
   endproperty
   a_data: assert property (p_data) else $error("data reply header wrong");
   property p_busy;
      RSP_VALID |-> !REQ_READY;
   endproperty
   a_busy: assert property (p_busy) else $error("request taken while replying");
   property p_stand;
      RSP_VALID && !RSP_READY |=> RSP_VALID && $stable(RSP_WORD) && $stable(RSP_CODE)
         && $stable(RSP_LAST);
   endproperty
   a_stand: assert property (p_stand) else $error("reply beat changed while stalled");
   property p_err_fields;
      RSP_VALID && RSP_ERROR |-> RSP_LAST && RSP_WORD == 16'h0000 && RSP_BYTE_COUNT == 8'h00;
   endproperty
   a_err_fields: assert property (p_err_fields) else $error("exception beat fields");
   property p_gap;
      RSP_VALID && RSP_READY && !RSP_LAST |=> !RSP_VALID ##1 RSP_VALID;
   endproperty
   a_gap: assert property (p_gap) else $error("next word not offered on time");
   property p_idle;
      RSP_VALID && RSP_READY && RSP_LAST |=> REQ_READY && !RSP_VALID;
   endproperty
   a_idle: assert property (p_idle) else $error("not idle after last beat");
   property p_reset;
      disable iff (1'b0) SYS_RST |=> REQ_READY && !RSP_VALID;
   endproperty
   a_reset: assert property (p_reset) else $error("reset state wrong");
   c_exc: cover property (taken && want != 8'h00);
   c_last: cover property (RSP_VALID && RSP_READY && RSP_LAST && !RSP_ERROR);
   c_stall: cover property (RSP_VALID && !RSP_READY);
endmodule // level_probe_register_bank_monitor

bind level_probe_register_bank level_probe_register_bank_monitor
   level_probe_register_bank_monitor_inst (.CLK_SYS, .SYS_RST, .REQ_VALID, .REQ_READY,
   .REQ_FUNCTION, .REQ_START, .REQ_QUANTITY, .RSP_VALID, .RSP_READY, .RSP_ERROR,
   .RSP_CODE, .RSP_BYTE_COUNT, .RSP_WORD, .RSP_LAST, .PROBE_FAULT, .MEMORY_FAULT);

// >>> verification/modbus_master_model.sv
// Request master model that feeds the register bank and gathers reply beats
`timescale 1ns/1ps
module modbus_master_model (
   input  logic        clk,
   input  logic        req_ready,
   input  logic        rsp_valid,
   input  logic        rsp_error,
   input  logic [7:0]  rsp_code,
   input  logic [7:0]  rsp_byte_count,
   input  logic [15:0] rsp_word,
   input  logic        rsp_last,
   output logic        req_valid,
   output logic [7:0]  req_function,
   output logic [15:0] req_start,
   output logic [15:0] req_quantity,
   output logic        rsp_ready
);
   // ---------------------------------------------------------------
   // Request side and reply collection
   // ---------------------------------------------------------------
   logic        stall;
   logic        got_last;
   logic [1:0]  phase;
   logic [33:0] beats[$];
   initial begin
      {req_valid, req_function, req_start, req_quantity} = '0;
      rsp_ready = 1'b1;
      {stall, phase, got_last} = '0;
   end
   task automatic send(input logic [7:0] f, input logic [15:0] s, input logic [15:0] q);
      @(negedge clk);
      got_last = 1'b0;
      req_function = f;
      req_start = s;
      req_quantity = q;
      req_valid = 1'b1;
      while (!req_ready) @(negedge clk);
      @(posedge clk);
      @(negedge clk);
      req_valid = 1'b0;
      // Stale fields are inverted so a late sample cannot pass by luck
      req_function = ~f;
      req_start = ~s;
      req_quantity = ~q;
   endtask
   // When stalling, the master takes only one cycle in four
   always @(negedge clk) begin
      phase <= phase + 2'h1;
      rsp_ready <= !stall || phase == 2'h3;
   end
   always @(posedge clk) begin
      if (rsp_valid && rsp_ready) begin
         beats.push_back({rsp_error, rsp_code, rsp_byte_count, rsp_word, rsp_last});
         if (rsp_last) got_last = 1'b1;
      end
   end
endmodule // modbus_master_model

// >>> verification/tb_level_probe_register_bank.sv
// Self-checking bench for the level probe register bank
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin fails++; \
   $display("wrong value %s expected %h seen %h", n, e, s); end end
module tb_level_probe_register_bank;
   logic        CLK_SYS, SYS_RST, REQ_VALID, REQ_READY, RSP_VALID, RSP_READY;
   logic        RSP_ERROR, RSP_LAST, PROBE_FAULT, MEMORY_FAULT;
   logic        PRIMARY_VARIABLE_OUT_OF_LIMIT, SECONDARY_TERTIARY_FOURTH_VARIABLES_OUT_OF_LIMIT;
   logic [7:0]  REQ_FUNCTION, RSP_CODE, RSP_BYTE_COUNT, SLAVE_ADDRESS;
   logic [15:0] REQ_START, REQ_QUANTITY, RSP_WORD, UNIT_CODE, REPLY_DELAY_MS;
   logic [31:0] USER_PERCENT_FLOAT, PRESSURE_FLOAT, TEMPERATURE_FLOAT, CPU_TEMPERATURE_FLOAT;
   logic [31:0] RANGE_UPPER_FLOAT, RANGE_LOWER_FLOAT, DAMPING_FLOAT, USER_PERCENT_SCALED;
   logic [31:0] PRESSURE_SCALED, TEMPERATURE_SCALED, CPU_TEMPERATURE_SCALED;
   logic [47:0] IDENTIFICATION;
   logic [39:0] corners[$] = '{40'h03_0023_0001, 40'h03_0023_0002, 40'h03_0024_0001,
      40'h03_FFFF_0001, 40'h03_0000_0000, 40'h03_0000_007E, 40'h03_0000_007D,
      40'h06_0011_0001, 40'h10_0000_0002, 40'h04_0000_0001, 40'h00_0000_0001};
   logic [15:0] units[3] = '{16'h0007, 16'h000E, 16'h000A};
   integer      seed = 32'heb3b;
   int          fails = 0;
   int          n_tests = 0;
   int          cyc = 0;
   level_probe_register_bank level_probe_register_bank_inst (.*);
   modbus_master_model modbus_master_model_inst (.clk(CLK_SYS), .req_ready(REQ_READY),
      .rsp_valid(RSP_VALID), .rsp_error(RSP_ERROR), .rsp_code(RSP_CODE),
      .rsp_byte_count(RSP_BYTE_COUNT), .rsp_word(RSP_WORD), .rsp_last(RSP_LAST),
      .req_valid(REQ_VALID), .req_function(REQ_FUNCTION), .req_start(REQ_START),
      .req_quantity(REQ_QUANTITY), .rsp_ready(RSP_READY));
   // ---------------------------------------------------------------
   // Expectations, stimulus and closing
   // ---------------------------------------------------------------
   initial begin
      CLK_SYS = 1'b0;
      forever #10 CLK_SYS = ~CLK_SYS;
   end
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge CLK_SYS) begin
      cyc++;
      if (cyc == 50000) begin
         fails++;
         close_out();
      end
   end
   function automatic logic [7:0] exp_code(logic [7:0] f, logic [15:0] s, logic [15:0] q);
      if (f != 8'h03) return 8'h01;
      if (q == 16'h0000 || q > 16'h007D) return 8'h03;
      if (s + q - 1 > 16'h0023) return 8'h02;
      if (PROBE_FAULT) return 8'h04;
      if (MEMORY_FAULT) return 8'h08;
      return 8'h00;
   endfunction
   function automatic logic [15:0] exp_word(int a);
      logic [31:0] f;
      case (a >> 1)
         0: f = USER_PERCENT_FLOAT;
         1: f = PRESSURE_FLOAT;
         3: f = TEMPERATURE_FLOAT;
         4: f = CPU_TEMPERATURE_FLOAT;
         12: f = RANGE_UPPER_FLOAT;
         13: f = RANGE_LOWER_FLOAT;
         14: f = DAMPING_FLOAT;
         default: f = 32'h0000_0000;
      endcase
      if (a < 16 || (a >= 24 && a < 30)) return a[0] ? f[15:0] : f[31:16];
      case (a)
         16: return USER_PERCENT_SCALED[15:0];
         17: return PRESSURE_SCALED[15:0];
         19: return TEMPERATURE_SCALED[15:0];
         20: return CPU_TEMPERATURE_SCALED[15:0];
         22: return UNIT_CODE;
         30: return REPLY_DELAY_MS;
         31: return {8'h00, SLAVE_ADDRESS};
         32: return IDENTIFICATION[47:32];
         33: return IDENTIFICATION[31:16];
         34: return IDENTIFICATION[15:0];
         35: return {9'h000, SECONDARY_TERTIARY_FOURTH_VARIABLES_OUT_OF_LIMIT,
            PRIMARY_VARIABLE_OUT_OF_LIMIT, 5'h00};
         default: return 16'h0000;
      endcase
   endfunction
   task automatic scramble();
      {USER_PERCENT_FLOAT, PRESSURE_FLOAT} = {$random(seed), $random(seed)};
      {TEMPERATURE_FLOAT, CPU_TEMPERATURE_FLOAT} = {$random(seed), $random(seed)};
      {RANGE_UPPER_FLOAT, RANGE_LOWER_FLOAT} = {$random(seed), $random(seed)};
      {DAMPING_FLOAT, USER_PERCENT_SCALED} = {$random(seed), $random(seed)};
      {PRESSURE_SCALED, TEMPERATURE_SCALED} = {$random(seed), $random(seed)};
      {CPU_TEMPERATURE_SCALED, UNIT_CODE, REPLY_DELAY_MS} = {$random(seed), $random(seed)};
      {IDENTIFICATION, SLAVE_ADDRESS} = 56'({$random(seed), $random(seed)});
      {PRIMARY_VARIABLE_OUT_OF_LIMIT, SECONDARY_TERTIARY_FOURTH_VARIABLES_OUT_OF_LIMIT} =
         2'($random(seed));
   endtask
   task automatic xfer(logic [7:0] f, logic [15:0] s, logic [15:0] q);
      logic [7:0]  code;
      logic [15:0] want[$];
      logic [33:0] b;
      int          n;
      code = exp_code(f, s, q);
      for (int a = 0; code == 8'h00 && a < q; a++) want.push_back(exp_word(s + a));
      modbus_master_model_inst.beats.delete();
      modbus_master_model_inst.send(f, s, q);
      // Values changed after the take must not show
      scramble();
      n = 0;
      while (!modbus_master_model_inst.got_last && n < 800) begin
         @(negedge CLK_SYS);
         n++;
      end
      `CHK("beat count", code != 8'h00 ? 1 : int'(q), modbus_master_model_inst.beats.size())
      n = 0;
      while (modbus_master_model_inst.beats.size() > 0) begin
         b = modbus_master_model_inst.beats.pop_front();
         if (code != 8'h00) `CHK("exception beat", {1'b1, code, 24'h00_0000, 1'b1}, b)
         else `CHK("data beat", {9'h003, 8'(q << 1), want[n], n == int'(q) - 1}, b)
         n++;
      end
   endtask
   initial begin
      SYS_RST = 1'b1;
      PROBE_FAULT = 1'b0;
      MEMORY_FAULT = 1'b0;
      scramble();
      repeat (8) @(posedge CLK_SYS);
      @(negedge CLK_SYS);
      `CHK("ready in reset", 1'b1, REQ_READY)
      `CHK("reply in reset", 1'b0, RSP_VALID)
      SYS_RST = 1'b0;
      xfer(8'h03, 16'h0000, 16'h0024);
      modbus_master_model_inst.stall = 1'b1;
      xfer(8'h03, 16'h0000, 16'h0024);
      foreach (units[k]) begin
         UNIT_CODE = units[k];
         xfer(8'h03, 16'h0016, 16'h0001);
      end
      foreach (corners[k]) xfer(corners[k][39:32], corners[k][31:16], corners[k][15:0]);
      PRESSURE_SCALED = 32'h0001_8001;
      xfer(8'h03, 16'h0011, 16'h0001);
      PROBE_FAULT = 1'b1;
      xfer(8'h03, 16'h0002, 16'h0002);
      MEMORY_FAULT = 1'b1;
      xfer(8'h03, 16'h0002, 16'h0002);
      PROBE_FAULT = 1'b0;
      xfer(8'h03, 16'h0002, 16'h0002);
      for (int k = 0; k < 40; k++) begin
         PROBE_FAULT = 3'($random(seed)) == 3'h0;
         MEMORY_FAULT = 3'($random(seed)) == 3'h0;
         modbus_master_model_inst.stall = 1'($random(seed));
         xfer(2'($random(seed)) == 2'h0 ? 8'($random(seed)) : 8'h03,
            16'(6'($random(seed))), 16'(6'($random(seed))));
      end
      close_out();
   end
endmodule // tb_level_probe_register_bank
